/* File: hdl/dgpio_defines.vh */
`ifndef DGPIO_DEFINES_VH
`define DGPIO_DEFINES_VH

// register byte addresses
`define DGPIO_OFF_PINS_A     8'h00
`define DGPIO_OFF_LATCH_A    8'h04
`define DGPIO_OFF_DIR_A      8'h08
`define DGPIO_OFF_ANALOG_SELECT_BIT      8'h0c
`define DGPIO_OFF_SEG1       8'h10
`define DGPIO_OFF_SEG2       8'h14
`define DGPIO_OFF_SEG3       8'h18
`define DGPIO_OFF_PINS_B     8'h1c
`define DGPIO_OFF_LATCH_B    8'h20
`define DGPIO_OFF_DIR_B      8'h24
`define DGPIO_OFF_IRQ_MAIN   8'h28
`define DGPIO_OFF_IRQ_SECOND 8'h2c
`define DGPIO_OFF_IRQ_THIRD  8'h30
`define DGPIO_OFF_OSC_CFG    8'h34

// reset values
`define DGPIO_RST_ZERO8      8'h00
`define DGPIO_RST_DIR        8'hff
`define DGPIO_RST_ANALOG_SELECT_BIT      8'h1f
`define DGPIO_RST_IRQ_SECOND 8'h80
`define DGPIO_RST_OSC_CFG    8'h00
`define DGPIO_RST_NIB        4'h0
`define DGPIO_RST_DIV        2'h0

// field positions
`define DGPIO_BIT_CHANGE_FLAG 0
`define DGPIO_BIT_CHANGE_IE   3
`define DGPIO_BIT_PULLUP_DIS  7
`define DGPIO_OSC_MODE_HI     1
`define DGPIO_OSC_MODE_LO     0
`define DGPIO_BIT_CLKOUT_EN   2
`define DGPIO_DIV_MSB         1

// oscillator modes
`define DGPIO_MODE_FAST_XTAL  2'h0
`define DGPIO_MODE_EXT_CLK    2'h1
`define DGPIO_MODE_INT_OSC    2'h2

// analog select bit of each analog pin of port a
`define DGPIO_AN_A0 0
`define DGPIO_AN_A1 1
`define DGPIO_AN_A2 2
`define DGPIO_AN_A3 3
`define DGPIO_AN_A5 4

// segment enable bit of each shared pin
`define DGPIO_SEG_A1 2
`define DGPIO_SEG_A4 6
`define DGPIO_SEG_A5 7
`define DGPIO_SEG_B0 6
`define DGPIO_SEG_B1 0
`define DGPIO_SEG_B2 1
`define DGPIO_SEG_B3 2
`define DGPIO_SEG_B4 3
`define DGPIO_SEG_B5 5

`endif

/* File: hdl/dgpio_top.v */
// How it works
// - each port has eight pins with separate direction and latch bits
// - direction one makes pin input, zero drives latch value onto pin
// - pin-level register reads the pins; writing it updates the output latch
// - analog select bits pick analog use; direction bits still steer the pin
// - after reset a0-a3 and a5 are analog reading zero, a4 digital input
// - analog use cuts the pin-register read only; latch output and peripheral inputs unaffected
// - crystal or external clock modes: a6/a7 not gpio, dir and latch read zero
// - internal oscillator mode with clock out off: a6/a7 become plain digital gpio
// - external clock mode, and internal mode with clock out on, drive clock out at hclk divided by four
// - segment enable gives pin to segment drive, overriding everything else
// - active capture/compare output on b3 overrides latch value
// - clearing pull-up disable bit enables weak pull-ups on port b
// - pull-up of a port b pin is off while that pin is output
// - reset leaves all port b pull-ups disabled
// - b4-b7 change detection, input pins only
// - mismatch against value latched at last port b pin-level register access (read or write) sets change flag
// - flag keeps setting while mismatch lasts; port b pin-level register access ends the mismatch
// - change flag can wake the device from power-managed modes
// - timer, fault and programming inputs ignore the direction bits
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "dgpio_defines.vh"

module dgpio_top
(
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // port a pins
    input  wire [7:0]  pin_a_in,
    output reg  [7:0]  pin_a_out,
    output reg  [7:0]  pin_a_oe,
    output reg  [7:0]  analog_en_a,
    // port b pins
    input  wire [7:0]  pin_b_in,
    output reg  [7:0]  pin_b_out,
    output reg  [7:0]  pin_b_oe,
    output reg  [7:0]  pullup_en_b,
    // peripheral side, same clock
    input  wire [7:0]  seg_drive_a,
    input  wire [7:0]  seg_drive_b,
    input  wire        enh_capture_unit2_out,
    input  wire        enh_capture_unit2_out_en,
    input  wire        prog_mode,
    input  wire        prog_data_out,
    input  wire        prog_data_oe,
    output reg  [7:0]  periph_in_a,
    output reg  [7:0]  periph_in_b,
    // change event
    output reg         port_change_flag,
    output reg         port_change_wake
);

    // register state
    reg  [7:0]  out_latch_a;
    reg  [7:0]  dir_a;
    reg  [7:0]  analog_select_high;
    reg  [7:0]  segment_enable_one;
    reg  [7:0]  segment_enable_two;
    reg  [7:0]  segment_enable_three;
    reg  [7:0]  out_latch_b;
    reg  [7:0]  dir_b;
    reg  [7:0]  irq_main_rest;
    reg  [7:0]  irq_control_second;
    reg  [7:0]  irq_control_third;
    reg  [7:0]  osc_cfg;
    reg  [3:0]  change_ref;
    reg  [1:0]  div_cnt;

    // synchronisers
    reg  [7:0]  sync1_a;
    reg  [7:0]  sync2_a;
    reg  [7:0]  sync1_b;
    reg  [7:0]  sync2_b;

    // bus phase capture
    reg         wr_pend;
    reg  [7:0]  wr_addr;

    wire        addr_phase;
    wire        rd_take;
    wire        wr_take;
    wire [7:0]  addr_lo;
    wire [1:0]  osc_mode;
    wire        osc_pins_gpio;
    wire        clkout_on;
    wire [7:0]  analog_pins_a;
    wire [7:0]  seg_a;
    wire [7:0]  seg_b;
    wire [7:0]  osc_mask;
    wire [7:0]  pins_a_rd;
    wire        port_b_touch;
    wire        mismatch;
    wire        flag_clear;
    wire        flag_set;
    wire [7:0]  pullup_ok_b;

    reg  [31:0] next_hrdata;
    reg  [7:0]  next_pin_a_out;
    reg  [7:0]  next_pin_a_oe;
    reg  [7:0]  next_pin_b_out;
    reg  [7:0]  next_pin_b_oe;

    // only haddr[7:0] is decoded, so the map repeats through the upper address space
    assign addr_phase = hsel & htrans[1] & hready;
    assign rd_take    = addr_phase & ~hwrite;
    assign wr_take    = addr_phase & hwrite;
    assign addr_lo    = haddr[7:0];

    // mode 3 is undefined and behaves like the crystal mode
    assign osc_mode      = osc_cfg[`DGPIO_OSC_MODE_HI:`DGPIO_OSC_MODE_LO];
    assign osc_pins_gpio = (osc_mode == `DGPIO_MODE_INT_OSC) &
                           ~osc_cfg[`DGPIO_BIT_CLKOUT_EN];
    // internal mode with clock out still gives a6 over to the divided clock
    assign clkout_on     = (osc_mode == `DGPIO_MODE_EXT_CLK) |
                           ((osc_mode == `DGPIO_MODE_INT_OSC) &
                            osc_cfg[`DGPIO_BIT_CLKOUT_EN]);
    assign osc_mask      = osc_pins_gpio ? 8'hff : 8'h3f;

    // select bits 0-4 sit on a0-a3 and a5; a4 has no analog use
    assign analog_pins_a = {2'h0,
                            analog_select_high[`DGPIO_AN_A5],
                            1'b0,
                            analog_select_high[`DGPIO_AN_A3:`DGPIO_AN_A0]};

    // segment enables are spread over three registers, gathered here per pin
    assign seg_a = {2'h0,
                    segment_enable_one[`DGPIO_SEG_A5],
                    segment_enable_one[`DGPIO_SEG_A4],
                    2'h0,
                    segment_enable_two[`DGPIO_SEG_A1],
                    1'b0};
    assign seg_b = {2'h0,
                    segment_enable_three[`DGPIO_SEG_B5],
                    segment_enable_one[`DGPIO_SEG_B4],
                    segment_enable_one[`DGPIO_SEG_B3],
                    segment_enable_one[`DGPIO_SEG_B2],
                    segment_enable_one[`DGPIO_SEG_B1],
                    segment_enable_three[`DGPIO_SEG_B0]};

    // analog pins read zero; their path into the pin read is cut, periph_in_a still sees them
    assign pins_a_rd = sync2_a & ~analog_pins_a & osc_mask;

    // any access to port b pins relatches the change reference
    assign port_b_touch = addr_phase & (addr_lo == `DGPIO_OFF_PINS_B);
    // turning an output back to input can set the flag if the pin moved meanwhile
    assign mismatch     = |((sync2_b[7:4] ^ change_ref) & dir_b[7:4]);
    // writing one to bit 0 leaves the flag alone; software can only clear it
    assign flag_clear   = wr_pend & (wr_addr == `DGPIO_OFF_IRQ_MAIN) &
                          ~hwdata[`DGPIO_BIT_CHANGE_FLAG];
    assign flag_set     = mismatch;

    // pull-ups only where nothing drives, even when programming mode overrides
    assign pullup_ok_b  = {8{~irq_control_second[`DGPIO_BIT_PULLUP_DIS]}} &
                          dir_b & ~next_pin_b_oe;

    // read mux, registered at the address phase so hrdata comes from a flop
    // unmapped offsets read zero and take no write
    always @*
    begin
        next_hrdata = 32'h0000_0000;
        case (addr_lo)
            `DGPIO_OFF_PINS_A:     next_hrdata[7:0] = pins_a_rd;
            `DGPIO_OFF_LATCH_A:    next_hrdata[7:0] = out_latch_a & osc_mask;
            `DGPIO_OFF_DIR_A:      next_hrdata[7:0] = dir_a & osc_mask;
            `DGPIO_OFF_ANALOG_SELECT_BIT:      next_hrdata[7:0] = analog_select_high;
            `DGPIO_OFF_SEG1:       next_hrdata[7:0] = segment_enable_one;
            `DGPIO_OFF_SEG2:       next_hrdata[7:0] = segment_enable_two;
            `DGPIO_OFF_SEG3:       next_hrdata[7:0] = segment_enable_three;
            `DGPIO_OFF_PINS_B:     next_hrdata[7:0] = sync2_b;
            `DGPIO_OFF_LATCH_B:    next_hrdata[7:0] = out_latch_b;
            `DGPIO_OFF_DIR_B:      next_hrdata[7:0] = dir_b;
            `DGPIO_OFF_IRQ_MAIN:   next_hrdata[7:0] = {irq_main_rest[7:1],
                                                       port_change_flag};
            `DGPIO_OFF_IRQ_SECOND: next_hrdata[7:0] = irq_control_second;
            `DGPIO_OFF_IRQ_THIRD:  next_hrdata[7:0] = irq_control_third;
            `DGPIO_OFF_OSC_CFG:    next_hrdata[7:0] = osc_cfg;
            default:               next_hrdata = 32'h0000_0000;
        endcase
    end

    // pin drive: segment beats peripheral beats latch
    always @*
    begin
        next_pin_a_out = out_latch_a;
        next_pin_a_oe  = ~dir_a;
        if (!osc_pins_gpio)
        begin
            next_pin_a_out[7] = 1'b0;
            next_pin_a_oe[7]  = 1'b0;
            next_pin_a_out[6] = div_cnt[`DGPIO_DIV_MSB];
            next_pin_a_oe[6]  = clkout_on;
        end
        next_pin_a_out = (next_pin_a_out & ~seg_a) | (seg_drive_a & seg_a);
        next_pin_a_oe  = next_pin_a_oe | seg_a;

        next_pin_b_out = out_latch_b;
        next_pin_b_oe  = ~dir_b;
        // compare output only drives while the direction bit makes b3 an output
        if (enh_capture_unit2_out_en && !dir_b[3])
        begin
            next_pin_b_out[3] = enh_capture_unit2_out;
        end
        // programming mode: b6 is the clock input, b7 follows the data driver
        if (prog_mode)
        begin
            next_pin_b_oe[6]  = 1'b0;
            next_pin_b_oe[7]  = prog_data_oe;
            next_pin_b_out[7] = prog_data_out;
        end
        next_pin_b_out = (next_pin_b_out & ~seg_b) | (seg_drive_b & seg_b);
        next_pin_b_oe  = next_pin_b_oe | seg_b;
    end

    // pin synchronisers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_a <= `DGPIO_RST_ZERO8;
            sync2_a <= `DGPIO_RST_ZERO8;
            sync1_b <= `DGPIO_RST_ZERO8;
            sync2_b <= `DGPIO_RST_ZERO8;
        end
        else
        begin
            // first stage feeds nothing but the second, to contain metastability
            sync1_a <= pin_a_in;
            sync2_a <= sync1_a;
            sync1_b <= pin_b_in;
            sync2_b <= sync1_b;
        end
    end

    // bus and register file
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata               <= 32'h0000_0000;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
            wr_pend              <= 1'b0;
            wr_addr              <= `DGPIO_RST_ZERO8;
            out_latch_a          <= `DGPIO_RST_ZERO8;
            dir_a                <= `DGPIO_RST_DIR;
            analog_select_high   <= `DGPIO_RST_ANALOG_SELECT_BIT;
            segment_enable_one   <= `DGPIO_RST_ZERO8;
            segment_enable_two   <= `DGPIO_RST_ZERO8;
            segment_enable_three <= `DGPIO_RST_ZERO8;
            out_latch_b          <= `DGPIO_RST_ZERO8;
            dir_b                <= `DGPIO_RST_DIR;
            irq_main_rest        <= `DGPIO_RST_ZERO8;
            irq_control_second   <= `DGPIO_RST_IRQ_SECOND;
            irq_control_third    <= `DGPIO_RST_ZERO8;
            osc_cfg              <= `DGPIO_RST_OSC_CFG;
        end
        else
        begin
            // zero wait states, always okay
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take)
            begin
                hrdata <= next_hrdata;
            end
            // write data trails its address by a cycle, so the address waits here
            wr_pend <= wr_take;
            if (wr_take)
            begin
                wr_addr <= addr_lo;
            end
            if (wr_pend)
            begin
                case (wr_addr)
                    `DGPIO_OFF_PINS_A:     out_latch_a <= hwdata[7:0];
                    `DGPIO_OFF_LATCH_A:    out_latch_a <= hwdata[7:0];
                    `DGPIO_OFF_DIR_A:      dir_a <= hwdata[7:0];
                    `DGPIO_OFF_ANALOG_SELECT_BIT:      analog_select_high <= hwdata[7:0];
                    `DGPIO_OFF_SEG1:       segment_enable_one <= hwdata[7:0];
                    `DGPIO_OFF_SEG2:       segment_enable_two <= hwdata[7:0];
                    `DGPIO_OFF_SEG3:       segment_enable_three <= hwdata[7:0];
                    `DGPIO_OFF_PINS_B:     out_latch_b <= hwdata[7:0];
                    `DGPIO_OFF_LATCH_B:    out_latch_b <= hwdata[7:0];
                    `DGPIO_OFF_DIR_B:      dir_b <= hwdata[7:0];
                    `DGPIO_OFF_IRQ_MAIN:   irq_main_rest <= {hwdata[7:1], 1'b0};
                    `DGPIO_OFF_IRQ_SECOND: irq_control_second <= hwdata[7:0];
                    `DGPIO_OFF_IRQ_THIRD:  irq_control_third <= hwdata[7:0];
                    `DGPIO_OFF_OSC_CFG:    osc_cfg <= hwdata[7:0];
                    default:               osc_cfg <= osc_cfg;
                endcase
            end
        end
    end

    // change detection and clock-out divider
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            change_ref       <= `DGPIO_RST_NIB;
            port_change_flag <= 1'b0;
            port_change_wake <= 1'b0;
            div_cnt          <= `DGPIO_RST_DIV;
        end
        else
        begin
            // free-running divider; its phase is not tied to any bus event
            div_cnt <= div_cnt + 2'h1;
            // reference comes from the synchronised pins, the value a read returns
            if (port_b_touch)
            begin
                change_ref <= sync2_b[7:4];
            end
            // a set in the same cycle as a clear wins
            if (flag_set)
            begin
                port_change_flag <= 1'b1;
            end
            else if (flag_clear)
            begin
                port_change_flag <= 1'b0;
            end
            // wake trails the flag by one edge, so it never leads the flag bit
            port_change_wake <= port_change_flag &
                                irq_main_rest[`DGPIO_BIT_CHANGE_IE];
        end
    end

    // pin drive, pull-ups, analog enables, direction-free peripheral inputs
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_a_out   <= `DGPIO_RST_ZERO8;
            pin_a_oe    <= `DGPIO_RST_ZERO8;
            pin_b_out   <= `DGPIO_RST_ZERO8;
            pin_b_oe    <= `DGPIO_RST_ZERO8;
            pullup_en_b <= `DGPIO_RST_ZERO8;
            analog_en_a <= `DGPIO_RST_ZERO8;
            periph_in_a <= `DGPIO_RST_ZERO8;
            periph_in_b <= `DGPIO_RST_ZERO8;
        end
        else
        begin
            pin_a_out   <= next_pin_a_out;
            pin_a_oe    <= next_pin_a_oe;
            pin_b_out   <= next_pin_b_out;
            pin_b_oe    <= next_pin_b_oe;
            pullup_en_b <= pullup_ok_b;
            analog_en_a <= analog_pins_a & ~seg_a;
            // timer, fault and programming inputs see the pin whatever the direction
            periph_in_a <= sync2_a;
            periph_in_b <= sync2_b;
        end
    end

endmodule // dgpio_top

/* File: dv/dgpio_top_props.sv */
`timescale 1ns/10ps
module dgpio_top_props
(
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // watched ports
    input wire [31:0] hwdata,
    input wire [7:0]  pin_a_oe,
    input wire [7:0]  analog_en_a,
    input wire [7:0]  pin_b_in,
    input wire [7:0]  pin_b_out,
    input wire [7:0]  pin_b_oe,
    input wire [7:0]  pullup_en_b,
    input wire [7:0]  periph_in_b,
    input wire        enh_capture_unit2_out,
    input wire        enh_capture_unit2_out_en,
    input wire        port_change_flag,
    input wire        port_change_wake
);
    // edges since reset release; saturates so $past never reaches into reset
    logic [2:0] up_cnt;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            up_cnt <= 3'h0;
        else if (up_cnt != 3'h7)
            up_cnt <= up_cnt + 3'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESET_QUIET: assert property (up_cnt == 3'h2 |-> pin_a_oe == 8'h00 &&
        pullup_en_b == 8'h00) else $error("pin drive or pull-up on after reset");
    AST_ANALOG_RESET: assert property (up_cnt == 3'h2 |-> analog_en_a == 8'h2f)
        else $error("analog pins wrong after reset");
    AST_ANALOG_PINS: assert property (analog_en_a[7:6] == 2'h0 && !analog_en_a[4])
        else $error("analog use on a digital-only pin");
    AST_PULLUP_OUT: assert property ((pullup_en_b & pin_b_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_SYNC_DELAY: assert property (up_cnt == 3'h7 |-> periph_in_b == $past(pin_b_in, 3))
        else $error("pin sync latency wrong");
    AST_ECCP_WINS: assert property ($past(enh_capture_unit2_out_en) && pin_b_oe[3] |->
        pin_b_out[3] == $past(enh_capture_unit2_out)) else $error("compare output lost on b3");
    AST_WAKE_FLAG: assert property (port_change_wake |-> $past(port_change_flag))
        else $error("wake without change flag");
    AST_FLAG_CLEAR: assert property ($fell(port_change_flag) |-> !$past(hwdata[0]))
        else $error("change flag dropped without a clear");
endmodule // dgpio_top_props

bind dgpio_top dgpio_top_props i_props
(
    .hclk, .hresetn, .hwdata, .pin_a_oe, .analog_en_a, .pin_b_in, .pin_b_out, .pin_b_oe,
    .pullup_en_b, .periph_in_b, .enh_capture_unit2_out, .enh_capture_unit2_out_en, .port_change_flag, .port_change_wake
);

/* File: dv/dgpio_pins_model.sv */
`timescale 1ns/10ps
module dgpio_pins_model
(
    // clock
    input wire         hclk,
    // design pin drive
    input wire [7:0]   pin_a_out,
    input wire [7:0]   pin_a_oe,
    input wire [7:0]   pin_b_out,
    input wire [7:0]   pin_b_oe,
    input wire [7:0]   pullup_en_b,
    // external drivers
    input wire [7:0]   ext_a,
    input wire [7:0]   ext_a_en,
    input wire [7:0]   ext_b,
    input wire [7:0]   ext_b_en,
    // resolved levels
    output logic [7:0] pin_a_in,
    output logic [7:0] pin_b_in
);
    // floating lines wander so a stale level never passes as valid
    logic [7:0] wander = 8'h00;
    always @(posedge hclk)
        wander <= ~wander;
    assign pin_a_in = (pin_a_oe & pin_a_out) |
        (~pin_a_oe & ((ext_a_en & ext_a) | (~ext_a_en & wander)));
    assign pin_b_in = (pin_b_oe & pin_b_out) |
        (~pin_b_oe & ((ext_b_en & ext_b) | (~ext_b_en & (pullup_en_b | wander))));
endmodule // dgpio_pins_model

/* File: dv/dgpio_top_tb.sv */
`timescale 1ns/10ps
`include "dgpio_defines.vh"
module dgpio_top_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, port_change_flag, port_change_wake;
    logic [7:0]  pin_a_in, pin_a_out, pin_a_oe, analog_en_a, rdat, periph_in_a;
    logic [7:0]  pin_b_in, pin_b_out, pin_b_oe, pullup_en_b, periph_in_b;
    logic [7:0]  seg_drive_a = 8'h0, ext_a = 8'h0, ext_b = 8'h0;
    logic [7:0]  ext_a_en = 8'h0, ext_b_en = 8'h0;
    logic        enh_capture_unit2_out = 1'b0, enh_capture_unit2_out_en = 1'b0;
    logic        prog_mode = 1'b0, prog_data_out = 1'b0, prog_data_oe = 1'b0;
    int          fails = 0, compares = 0, cycles = 0;
    always #20 hclk = ~hclk;
    dgpio_top i_dut
    (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_a_in, .pin_a_out, .pin_a_oe,
        .analog_en_a, .pin_b_in, .pin_b_out, .pin_b_oe, .pullup_en_b, .seg_drive_a,
        .seg_drive_b(8'h00), .enh_capture_unit2_out, .enh_capture_unit2_out_en, .prog_mode, .prog_data_out,
        .prog_data_oe, .periph_in_a, .periph_in_b, .port_change_flag, .port_change_wake
    );
    dgpio_pins_model i_pins
    (
        .hclk, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe, .pullup_en_b,
        .ext_a, .ext_a_en, .ext_b, .ext_b_en, .pin_a_in, .pin_b_in
    );
    task automatic complete_run();
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run needs well under this
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            complete_run();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_ready();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rdat = hrdata[7:0];
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(rdat, exp);
    endtask
    // a6 at a quarter of hclk: every sample is the inverse of the one two edges back
    task automatic clk_out_chk();
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge hclk);
            s[i] = pin_a_out[6];
        end
        chk({2'h0, s[7:2] ^ s[5:0]}, 8'h3f);
        chk(pin_a_oe & 8'h40, 8'h40);
    endtask
    initial
    begin
        cyc(16);
        hresetn <= 1'b1;
        ext_a_en <= 8'hff;
        ext_a <= 8'hff;
        rchk(`DGPIO_OFF_DIR_A, 8'h3f);
        rchk(`DGPIO_OFF_DIR_B, 8'hff);
        rchk(`DGPIO_OFF_ANALOG_SELECT_BIT, 8'h1f);
        rchk(`DGPIO_OFF_IRQ_SECOND, 8'h80);
        rchk(`DGPIO_OFF_PINS_A, 8'h10);
        wr(8'h3c, 8'h55);
        rchk(8'h3c, 8'h00);
        chk({7'h0, hresp}, 8'h00);
        wr(`DGPIO_OFF_DIR_A, 8'h00);
        wr(`DGPIO_OFF_PINS_A, 8'h2a);
        rchk(`DGPIO_OFF_LATCH_A, 8'h2a);
        chk(pin_a_out & 8'h3f, 8'h2a);
        chk(pin_a_oe, 8'h3f);
        wr(`DGPIO_OFF_DIR_A, 8'hff);
        wr(`DGPIO_OFF_ANALOG_SELECT_BIT, 8'h00);
        ext_a <= 8'h35;
        cyc(3);
        rchk(`DGPIO_OFF_PINS_A, 8'h35);
        wr(`DGPIO_OFF_ANALOG_SELECT_BIT, 8'h11);
        rchk(`DGPIO_OFF_PINS_A, 8'h14);
        chk(analog_en_a, 8'h21);
        chk(periph_in_a, 8'h35);
        seg_drive_a <= 8'h10;
        wr(`DGPIO_OFF_SEG1, 8'h40);
        cyc(2);
        chk(pin_a_oe & pin_a_out & 8'h10, 8'h10);
        wr(`DGPIO_OFF_SEG1, 8'h00);
        wr(`DGPIO_OFF_OSC_CFG, 8'h02);
        wr(`DGPIO_OFF_DIR_A, 8'h3f);
        wr(`DGPIO_OFF_LATCH_A, 8'h40);
        rchk(`DGPIO_OFF_DIR_A, 8'h3f);
        rchk(`DGPIO_OFF_LATCH_A, 8'h40);
        chk(pin_a_oe & 8'hc0, 8'hc0);
        chk(pin_a_out & 8'hc0, 8'h40);
        for (int m = 0; m < 2; m++)
        begin
            wr(`DGPIO_OFF_OSC_CFG, m ? 8'h06 : 8'h01);
            cyc(2);
            clk_out_chk();
        end
        wr(`DGPIO_OFF_OSC_CFG, 8'h00);
        cyc(2);
        chk(pin_a_oe & 8'hc0, 8'h00);
        wr(`DGPIO_OFF_IRQ_SECOND, 8'h00);
        wr(`DGPIO_OFF_DIR_B, 8'h70);
        cyc(2);
        chk(pullup_en_b, 8'h70);
        enh_capture_unit2_out_en <= 1'b1;
        enh_capture_unit2_out <= 1'b1;
        cyc(3);
        chk(pin_b_out & 8'h08, 8'h08);
        enh_capture_unit2_out_en <= 1'b0;
        ext_b_en <= 8'hff;
        ext_b <= 8'h00;
        cyc(3);
        rchk(`DGPIO_OFF_PINS_B, 8'h00);
        cyc(1);
        wr(`DGPIO_OFF_IRQ_MAIN, 8'h08);
        wr(`DGPIO_OFF_LATCH_B, 8'h80);
        cyc(6);
        chk({7'h0, port_change_flag}, 8'h00);
        ext_b <= 8'h20;
        cyc(5);
        chk({6'h0, port_change_wake, port_change_flag}, 8'h03);
        wr(`DGPIO_OFF_IRQ_MAIN, 8'h08);
        cyc(1);
        chk({7'h0, port_change_flag}, 8'h01);
        rchk(`DGPIO_OFF_PINS_B, 8'ha0);
        cyc(1);
        wr(`DGPIO_OFF_IRQ_MAIN, 8'h08);
        cyc(1);
        chk({7'h0, port_change_flag}, 8'h00);
        rchk(`DGPIO_OFF_IRQ_MAIN, 8'h08);
        wr(`DGPIO_OFF_DIR_B, 8'h00);
        prog_mode <= 1'b1;
        prog_data_oe <= 1'b1;
        cyc(3);
        chk(pin_b_oe & 8'hc0, 8'h80);
        chk(pin_b_out & 8'h80, 8'h00);
        prog_mode <= 1'b0;
        cyc(2);
        complete_run();
    end
endmodule // dgpio_top_tb
